// [verif/rgo_ctrl_tb_top.sv]
// Purpose: self-checking bench of the regenerator loopback control
// Assumes: 100 MHz clock, loss persistence shortened to 20 cycles
// Notes: registers reached through an Avalon-MM master task
`timescale 1ns/10ps
`define CHK(g, e) check_eq(32'(g), 32'(e));
module rgo_ctrl_tb_top;
  localparam int LOSN = 20;
  localparam logic [1:0] REG = rgo_pkg::EOC_ADDR_REG;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata, rd;
  logic los_lfa_ltu_side_pin = 1'b0;
  logic los_lfa_ntu_side_pin = 1'b0;
  logic [1:0] supply_failure_pin = 2'h0;
  logic [2:0] alarm_source_pin = 3'h0;
  logic link_up_active = 1'b0;
  logic first_startup_signal_tx = 1'b0;
  logic bpv_detect = 1'b0;
  logic [7:0] ind_from_ltu = 8'hA5;
  logic [7:0] ind_from_ntu = 8'h3C;
  logic [3:0] own_ind = 4'h9;
  logic avs_waitrequest, eoc_rx_valid, eoc_tx_valid, eoc_pass_en, bpv_ovh;
  logic first_supply_failure, second_supply_failure, internal_alarm, ais_request;
  logic loop_closed, fwd_to_ntu_en, deact_ltu_side, deact_ntu_side, los_indication;
  logic ntu_side_deact, ntu_side_resync, start_ntu_startup, ref_clk;
  logic [1:0] eoc_rx_addr, eoc_tx_addr;
  logic [7:0] eoc_rx_code, eoc_tx_code, ind_to_ltu;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int edges = 0;
  int n;
  int unsigned khz[3] = '{rgo_pkg::REF_1P_KHZ, rgo_pkg::REF_2P_KHZ, rgo_pkg::REF_3P_KHZ};

  rgo_ctrl #(.LOS_CYCLES(LOSN)) dut (.clock, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .los_lfa_ltu_side_pin,
    .los_lfa_ntu_side_pin, .supply_failure_pin, .alarm_source_pin, .link_up_active,
    .first_startup_signal_tx, .eoc_rx_valid, .eoc_rx_addr, .eoc_rx_code, .eoc_tx_valid, .eoc_tx_addr,
    .eoc_tx_code, .eoc_pass_en, .ind_from_ltu, .ind_from_ntu, .own_ind, .ind_to_ltu, .bpv_detect,
    .bpv_ovh, .first_supply_failure, .second_supply_failure, .internal_alarm, .ais_request,
    .loop_closed, .fwd_to_ntu_en, .deact_ltu_side, .deact_ntu_side, .los_indication,
    .ntu_side_deact, .ntu_side_resync, .start_ntu_startup, .ref_clk);
  rgo_ltu_model ltu (.clock, .eoc_tx_valid, .eoc_rx_valid, .eoc_rx_addr, .eoc_rx_code);

  // clock and hang ceiling
  initial
  begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run;
    end
  end
  always @(posedge ref_clk) edges++;

  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one Avalon access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    do
    begin
      @(posedge clock);
    end
    while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    bus(0, rgo_pkg::OFS_CONFIG, 0, rd); `CHK(rd, rgo_pkg::CFG_RESET)
    // write with byte 0 disabled leaves the configuration alone
    avs_byteenable <= 4'h0;
    bus(1, rgo_pkg::OFS_CONFIG, 32'hFF, rd);
    avs_byteenable <= 4'h1;
    bus(0, rgo_pkg::OFS_CONFIG, 0, rd); `CHK(rd, rgo_pkg::CFG_RESET)
    bus(1, rgo_pkg::OFS_STATUS, 32'hFFFF, rd);
    bus(0, rgo_pkg::OFS_STATUS, 0, rd); `CHK(rd, 0)
    bus(1, 4'h8, 32'h5A, rd);
    bus(0, 4'h8, 0, rd); `CHK(rd, 0)
    `CHK({ind_to_ltu, eoc_pass_en, fwd_to_ntu_en}, 10'h0E7)
    ltu.send(REG, rgo_pkg::EOC_LOOP_REQ); #1 `CHK(loop_closed, 0)
    @(posedge clock);
    first_startup_signal_tx <= 1'b1;
    ltu.send(REG, rgo_pkg::EOC_LOOP_REQ); #1 `CHK(loop_closed, 1)
    repeat (2) @(posedge clock); #1 `CHK({ind_to_ltu, eoc_pass_en, fwd_to_ntu_en}, 10'h2A5)
    bus(0, rgo_pkg::OFS_STATUS, 0, rd); `CHK(rd[0], 1)
    ltu.send(2'h1, 8'h05); #1 `CHK({eoc_tx_valid, eoc_tx_addr, eoc_tx_code}, {1'b1, REG, rgo_pkg::EOC_HOLD_STATE})
    ltu.send(REG, 8'h05); #1 `CHK({eoc_tx_valid, loop_closed, 8'(ltu.replies)}, 10'h101)
    ltu.send(REG, rgo_pkg::EOC_RETURN_NORMAL); #1 `CHK({loop_closed, ntu_side_deact, start_ntu_startup}, 3'b010)
    @(posedge clock);
    link_up_active <= 1'b1;
    first_startup_signal_tx <= 1'b0;
    ltu.send(REG, rgo_pkg::EOC_LOOP_REQ); #1 `CHK({loop_closed, ntu_side_resync}, 2'b11)
    ltu.send(REG, rgo_pkg::EOC_RETURN_NORMAL); #1 `CHK({loop_closed, ntu_side_deact, start_ntu_startup}, 3'b011)
    // loss on each line side in turn, the first with the loop closed
    for (int s = 0; s < 2; s++)
    begin
      if (s == 0)
        ltu.send(REG, rgo_pkg::EOC_LOOP_REQ);
      @(posedge clock);
      los_lfa_ntu_side_pin <= (s == 0);
      los_lfa_ltu_side_pin <= (s == 1);
      n = 0;
      do
      begin
        @(posedge clock); #1;
        n++;
      end
      while (deact_ntu_side !== 1'b1 && n < 100);
      `CHK(n >= LOSN && n <= LOSN + 5, 1)
      `CHK({deact_ltu_side, los_indication, loop_closed, fwd_to_ntu_en}, 4'b1100)
      @(posedge clock);
      los_lfa_ntu_side_pin <= 1'b0;
      los_lfa_ltu_side_pin <= 1'b0;
      repeat (6) @(posedge clock); #1 `CHK({deact_ltu_side, deact_ntu_side, los_indication}, 0)
    end
    bus(1, rgo_pkg::OFS_CONFIG, 32'h0D, rd);
    alarm_source_pin <= 3'h4;
    supply_failure_pin <= 2'h2;
    bpv_detect <= 1'b1;
    repeat (4) @(posedge clock); #1 `CHK({internal_alarm, ais_request, ind_to_ltu[1], bpv_ovh}, 4'hF)
    `CHK({first_supply_failure, second_supply_failure}, 2'b10)
    bus(0, rgo_pkg::OFS_STATUS, 0, rd); `CHK(rd[9:4], 6'h32)
    bus(1, rgo_pkg::OFS_CONFIG, 32'h03, rd);
    supply_failure_pin <= 2'h1;
    repeat (4) @(posedge clock); #1 `CHK({internal_alarm, ais_request, bpv_ovh}, 3'b000)
    `CHK({first_supply_failure, second_supply_failure}, 2'b01)
    // reference clock rate for each pair count
    for (int p = 0; p < 3; p++)
    begin
      bus(1, rgo_pkg::OFS_CONFIG, 32'h01 | (p << 4), rd);
      repeat (50) @(posedge clock);
      edges = 0;
      repeat (1000) @(posedge clock);
      n = int'(khz[p] * 1000 / rgo_pkg::CLK_KHZ);
      `CHK(edges >= n - 1 && edges <= n + 1, 1)
    end
    complete_run;
  end
endmodule // rgo_ctrl_tb_top

// [verif/rgo_ltu_model.sv]
// Purpose: model of the line terminating unit side of the operations channel
// Assumes: one message per call, launched just after a rising edge
// Notes: released address and code lines show the inverse of the last value
`timescale 1ns/10ps
module rgo_ltu_model (
  input wire logic clock,
  input wire logic eoc_tx_valid,
  output logic eoc_rx_valid,
  output logic [1:0] eoc_rx_addr,
  output logic [7:0] eoc_rx_code
);
  int replies = 0;
  initial
  begin
    eoc_rx_valid = 1'b0;
    eoc_rx_addr = 2'h0;
    eoc_rx_code = 8'h00;
  end
  // count replies coming back toward the central unit
  always @(posedge clock)
  begin
    if (eoc_tx_valid === 1'b1)
      replies <= replies + 1;
  end
  task automatic send(input logic [1:0] a, input logic [7:0] c);
    @(posedge clock);
    eoc_rx_valid <= 1'b1;
    eoc_rx_addr <= a;
    eoc_rx_code <= c;
    @(posedge clock);
    eoc_rx_valid <= 1'b0;
    eoc_rx_addr <= ~a;
    eoc_rx_code <= ~c;
  endtask
endmodule // rgo_ltu_model

// [verilog/rgo_ctrl.sv]
// Purpose: regenerator loopback, deactivation and overhead indication control
// Assumes: eoc message strobes come from logic on the same clock
// Notes: registers reached over an Avalon-MM slave with waitrequest
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
module rgo_ctrl #(
  parameter int IND_W = 8,
  parameter int unsigned LOS_CYCLES = rgo_pkg::LOS_PERSIST_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic los_lfa_ltu_side_pin,
  input wire logic los_lfa_ntu_side_pin,
  input wire logic [1:0] supply_failure_pin,
  input wire logic [2:0] alarm_source_pin,
  input wire logic link_up_active,
  input wire logic first_startup_signal_tx,
  input wire logic eoc_rx_valid,
  input wire logic [1:0] eoc_rx_addr,
  input wire logic [7:0] eoc_rx_code,
  output logic eoc_tx_valid,
  output logic [1:0] eoc_tx_addr,
  output logic [7:0] eoc_tx_code,
  output logic eoc_pass_en,
  input wire logic [IND_W-1:0] ind_from_ltu,
  input wire logic [IND_W-1:0] ind_from_ntu,
  input wire logic [rgo_pkg::IND_OWN_W-1:0] own_ind,
  output logic [IND_W-1:0] ind_to_ltu,
  input wire logic bpv_detect,
  output logic bpv_ovh,
  output logic first_supply_failure,
  output logic second_supply_failure,
  output logic internal_alarm,
  output logic ais_request,
  output logic loop_closed,
  output logic fwd_to_ntu_en,
  output logic deact_ltu_side,
  output logic deact_ntu_side,
  output logic los_indication,
  output logic ntu_side_deact,
  output logic ntu_side_resync,
  output logic start_ntu_startup,
  output logic ref_clk
);
  localparam int CW = $clog2(LOS_CYCLES + 1);
  localparam int OW = rgo_pkg::IND_OWN_W;

  typedef struct packed {
    rgo_pkg::rgo_state_e st;
    logic [CW-1:0] los_cnt;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] cfg;
    logic hold_tx;
    logic ntu_deact;
    logic ntu_start;
    logic ntu_resync;
    logic [31:0] nco;
    logic [IND_W-1:0] ind;
    logic bpv;
    logic [1:0] supply;
    logic alarm;
  } rgo_ctrl_s;
  rgo_ctrl_s s;
  rgo_ctrl_s next_s;

  logic [6:0] pins;
  logic los_ltu;
  logic los_ntu;
  logic los_any;
  logic is_reg;
  logic loop_req;
  logic rtn_req;
  logic los_expire;
  logic bus_req;
  logic [7:0] be_mask;

  // phase increment for the selected pair count
  function automatic logic [31:0] nco_inc(input logic [1:0] pairs);
    unique case (pairs)
      rgo_pkg::PAIR_TWO: nco_inc = rgo_pkg::NCO_INC_2P;
      rgo_pkg::PAIR_THREE: nco_inc = rgo_pkg::NCO_INC_3P;
      default: nco_inc = rgo_pkg::NCO_INC_1P;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  rgo_sync #(
    .W(7)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .pin_in({los_lfa_ltu_side_pin, los_lfa_ntu_side_pin, supply_failure_pin, alarm_source_pin}),
    .level_out(pins)
  );

  // decode of events
  assign los_ltu = pins[6];
  assign los_ntu = pins[5];
  assign los_any = los_ltu | los_ntu;
  assign is_reg = eoc_rx_addr == rgo_pkg::EOC_ADDR_REG;
  assign loop_req = eoc_rx_valid & is_reg & (eoc_rx_code == rgo_pkg::EOC_LOOP_REQ);
  assign rtn_req = eoc_rx_valid & is_reg & (eoc_rx_code == rgo_pkg::EOC_RETURN_NORMAL);
  assign los_expire = los_any & (s.los_cnt == CW'(LOS_CYCLES - 1));
  assign bus_req = avs_read | avs_write;
  assign be_mask = {8{avs_byteenable[0]}};

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.hold_tx = 1'b0;
    next_s.ntu_deact = 1'b0;
    next_s.ntu_start = 1'b0;
    next_s.ntu_resync = 1'b0;
    next_s.los_cnt = (los_any && s.st != rgo_pkg::RGO_DOWN) ? s.los_cnt + CW'(1) : '0;
    unique case (s.st)
      rgo_pkg::RGO_NORMAL:
      begin
        if (loop_req && (link_up_active || first_startup_signal_tx))
        begin
          next_s.st = rgo_pkg::RGO_LOOP;
          next_s.ntu_resync = link_up_active;
        end
      end
      rgo_pkg::RGO_LOOP:
      begin
        next_s.hold_tx = eoc_rx_valid & ~is_reg;
        if (rtn_req)
        begin
          next_s.st = rgo_pkg::RGO_NORMAL;
          next_s.ntu_deact = 1'b1;
          next_s.ntu_start = link_up_active;
        end
      end
      rgo_pkg::RGO_DOWN:
      begin
        if (!los_any)
          next_s.st = rgo_pkg::RGO_NORMAL;
      end
      default: next_s.st = rgo_pkg::RGO_NORMAL;
    endcase
    // both sides down, loop flag dropped
    if (los_expire && s.st != rgo_pkg::RGO_DOWN)
    begin
      next_s.st = rgo_pkg::RGO_DOWN;
      next_s.hold_tx = 1'b0;
      next_s.ntu_start = 1'b0;
      next_s.ntu_deact = 1'b0;
    end
    // indicator loopback with own bits kept
    next_s.ind = (s.st == rgo_pkg::RGO_LOOP) ? ind_from_ltu : ind_from_ntu;
    next_s.ind[OW-1:0] = own_ind;
    next_s.ind[rgo_pkg::IND_ALARM_POS] = s.alarm;
    next_s.supply = pins[4:3];
    next_s.alarm = |pins[2:0] & ~s.cfg[rgo_pkg::CFG_ALARM_MASK];
    next_s.bpv = bpv_detect & s.cfg[rgo_pkg::CFG_BPV_EN];
    next_s.nco = s.nco + nco_inc(s.cfg[rgo_pkg::CFG_PAIR_LSB +: 2]);
    // bus slave: answer on the second cycle
    next_s.ack = bus_req & ~s.ack;
    next_s.rdata = '0;
    if (avs_read && !s.ack)
    begin
      if (avs_address == rgo_pkg::OFS_CONFIG)
        next_s.rdata = {24'h000000, s.cfg};
      else if (avs_address == rgo_pkg::OFS_STATUS)
      begin
        next_s.rdata[rgo_pkg::STS_LOOP] = s.st == rgo_pkg::RGO_LOOP;
        next_s.rdata[rgo_pkg::STS_LOS_IND] = s.st == rgo_pkg::RGO_DOWN;
        next_s.rdata[rgo_pkg::STS_LOS_LTU] = los_ltu;
        next_s.rdata[rgo_pkg::STS_LOS_NTU] = los_ntu;
        next_s.rdata[rgo_pkg::STS_SUPPLY_LSB +: 2] = s.supply;
        next_s.rdata[rgo_pkg::STS_ALARM_LSB +: 3] = pins[2:0];
        next_s.rdata[rgo_pkg::STS_INT_ALARM] = s.alarm;
      end
    end
    if (avs_write && s.ack && avs_address == rgo_pkg::OFS_CONFIG)
      next_s.cfg = (s.cfg & ~be_mask) | (avs_writedata[7:0] & be_mask);
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.st <= rgo_pkg::RGO_NORMAL;
      s.cfg <= rgo_pkg::CFG_RESET;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = bus_req & ~s.ack;
  assign avs_readdata = s.rdata;
  assign eoc_tx_valid = s.hold_tx;
  assign eoc_tx_addr = rgo_pkg::EOC_ADDR_REG;
  assign eoc_tx_code = rgo_pkg::EOC_HOLD_STATE;
  assign eoc_pass_en = s.st != rgo_pkg::RGO_LOOP;
  assign ind_to_ltu = s.ind;
  assign bpv_ovh = s.bpv;
  assign first_supply_failure = s.supply[1];
  assign second_supply_failure = s.supply[0];
  assign internal_alarm = s.alarm;
  assign ais_request = s.alarm & s.cfg[rgo_pkg::CFG_AIS_ON_FAULT];
  assign loop_closed = s.st == rgo_pkg::RGO_LOOP;
  assign fwd_to_ntu_en = s.st != rgo_pkg::RGO_DOWN;
  assign deact_ltu_side = s.st == rgo_pkg::RGO_DOWN;
  assign deact_ntu_side = s.st == rgo_pkg::RGO_DOWN;
  assign los_indication = s.st == rgo_pkg::RGO_DOWN;
  assign ntu_side_deact = s.ntu_deact;
  assign ntu_side_resync = s.ntu_resync;
  assign start_ntu_startup = s.ntu_start;
  assign ref_clk = s.nco[31];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_los_ind;
    los_expire && !los_indication |=> los_indication;
  endproperty
  a_los_ind: assert property (p_los_ind) else $error("loss indication missing");

  property p_both_down;
    los_expire && !los_indication |=> deact_ltu_side && deact_ntu_side && !loop_closed;
  endproperty
  a_both_down: assert property (p_both_down) else $error("both sides not deactivated");

  property p_close;
    !los_expire && !loop_closed && !los_indication && loop_req && link_up_active |=> loop_closed ##0 ntu_side_resync;
  endproperty
  a_close: assert property (p_close) else $error("loop not closed on request");

  property p_forward;
    loop_closed |-> fwd_to_ntu_en && !eoc_pass_en;
  endproperty
  a_forward: assert property (p_forward) else $error("loop not transparent");

  property p_hold;
    loop_closed && !los_expire && eoc_rx_valid && !is_reg |=> eoc_tx_valid && eoc_tx_code == rgo_pkg::EOC_HOLD_STATE;
  endproperty
  a_hold: assert property (p_hold) else $error("hold-state reply missing");

  property p_ind_loop;
    loop_closed |=> ind_to_ltu[IND_W-1:OW] == $past(ind_from_ltu[IND_W-1:OW]);
  endproperty
  a_ind_loop: assert property (p_ind_loop) else $error("indicators not looped");

  property p_return;
    loop_closed && rtn_req && !los_expire |=> !loop_closed && ntu_side_deact && start_ntu_startup == $past(link_up_active);
  endproperty
  a_return: assert property (p_return) else $error("return to normal mishandled");

  property p_flag_drop;
    loop_closed ##1 !loop_closed |-> ntu_side_deact || deact_ltu_side;
  endproperty
  a_flag_drop: assert property (p_flag_drop) else $error("loop flag cleared without cause");

  property p_bus;
    bus_req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
endmodule // rgo_ctrl

// [verilog/rgo_pkg.sv]
// Purpose: shared constants and types of the regenerator loopback and overhead control
// Assumes: 100 MHz system clock, 32-bit register words at byte addresses
// Notes: message codes and the persistence time scale the control block
package rgo_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned LOS_PERSIST_MS = 2000;
  localparam int unsigned LOS_PERSIST_CYCLES = LOS_PERSIST_MS * CLK_KHZ;
  // transceiver reference clocks in kHz for one, two and three pairs
  localparam int unsigned REF_1P_KHZ = 2320;
  localparam int unsigned REF_2P_KHZ = 1168;
  localparam int unsigned REF_3P_KHZ = 784;
  // phase increments of a 32-bit accumulator
  localparam logic [31:0] NCO_INC_1P = 32'((64'(REF_1P_KHZ) << 32) / 64'(CLK_KHZ));
  localparam logic [31:0] NCO_INC_2P = 32'((64'(REF_2P_KHZ) << 32) / 64'(CLK_KHZ));
  localparam logic [31:0] NCO_INC_3P = 32'((64'(REF_3P_KHZ) << 32) / 64'(CLK_KHZ));
  // ----------------------------------------------------------------
  // operations channel
  // ----------------------------------------------------------------
  localparam logic [1:0] EOC_ADDR_REG = 2'h2;
  localparam logic [7:0] EOC_LOOP_REQ = 8'h31;
  localparam logic [7:0] EOC_RETURN_NORMAL = 8'h3F;
  localparam logic [7:0] EOC_HOLD_STATE = 8'h3E;
  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  // configuration fields
  localparam int CFG_TRANSPARENT = 0;
  localparam int CFG_ALARM_MASK = 1;
  localparam int CFG_AIS_ON_FAULT = 2;
  localparam int CFG_BPV_EN = 3;
  localparam int CFG_PAIR_LSB = 4;
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam logic [1:0] PAIR_ONE = 2'h0;
  localparam logic [1:0] PAIR_TWO = 2'h1;
  localparam logic [1:0] PAIR_THREE = 2'h2;
  // status fields
  localparam int STS_LOOP = 0;
  localparam int STS_LOS_IND = 1;
  localparam int STS_LOS_LTU = 2;
  localparam int STS_LOS_NTU = 3;
  localparam int STS_SUPPLY_LSB = 4;
  localparam int STS_ALARM_LSB = 6;
  localparam int STS_INT_ALARM = 9;
  // own indicator positions in the indicator word
  localparam int IND_OWN_W = 4;
  localparam int IND_ALARM_POS = 1;
  // control states, one-hot
  typedef enum logic [2:0] {
    RGO_NORMAL = 3'h1,
    RGO_LOOP = 3'h2,
    RGO_DOWN = 3'h4
  } rgo_state_e;
endpackage

// [verilog/rgo_sync.sv]
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module rgo_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rgo_sync_s;
  rgo_sync_s s;
  rgo_sync_s next_s;

  // shift pins through both stages
  always_comb
  begin
    next_s.meta = pin_in;
    next_s.stable = s.meta;
  end

  // register stages
  always_ff @(posedge clock)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign level_out = s.stable;
endmodule // rgo_sync
